// file: rtl/scu_pkg.sv
/*
 * holds the shared constants and carriers of the serial unit: register
 * offsets, field layouts, reset values and the transmit state encoding.
 * assumes the unit reaches software over a plain 3-bit word address port.
 */
package scu_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [2:0] SCU_A_CTRL = 3'h0;   // serial_control_reg
    localparam logic [2:0] SCU_A_STAT = 3'h1;   // serial_status_reg
    localparam logic [2:0] SCU_A_TXB  = 3'h2;   // tx_buffer
    localparam logic [2:0] SCU_A_RXB  = 3'h3;   // rx_buffer
    localparam logic [2:0] SCU_A_BAUD = 3'h4;   // baud divisor

    // ------------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------------
    localparam logic [3:0] SCU_OVS_LAST  = 4'hF; // last of 16 ticks per bit
    localparam logic [3:0] SCU_MID       = 4'h7; // sample point in a bit
    localparam logic [2:0] SCU_HALF_LAST = 3'h7; // last of 8 ticks per half shift clock
    localparam logic [3:0] SCU_EDGE_LAST = 4'hF; // 16 edges, 8 pulses
    localparam logic [3:0] SCU_SYNC_LAST = 4'h7; // 8 bits per character
    localparam logic [3:0] SCU_LAST_PLN  = 4'h9; // stop index, no extra bit
    localparam logic [3:0] SCU_LAST_EXT  = 4'hA; // stop index, extra bit

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] rsv;
        logic       tx_end_irq_en;
        logic       tx_irq_en;
        logic       rx_irq_en;
        logic       multiproc_rx_filter_en;
        logic       clk_sel_hi;             // 1: external clock
        logic       clk_sel_lo;
        logic       par_odd;
        logic       par_en;
        logic       mp_fmt;                 // multiprocessor format
        logic       sync_mode;              // clock synchronous mode
        logic       rx_enable_bit;
        logic       tx_enable_bit;
    } scu_ctrl_t;

    typedef struct packed {
        logic [7:0] rsv;
        logic       tx_multiproc_flag_bit;
        logic       rx_multiproc_flag_bit;
        logic       tx_end_flag;
        logic       parity_err_flag;
        logic       framing_err_flag;
        logic       overrun_err_flag;
        logic       rx_full_flag;
        logic       tx_empty_flag;
    } scu_stat_t;

    typedef enum logic [1:0] {
        SCU_TX_IDLE = 2'b00,
        SCU_TX_RUN  = 2'b01
    } scu_tx_st_t;

    typedef struct packed {
        scu_ctrl_t  ctrl;
        scu_stat_t  stat;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic [7:0] baud;
    } scu_regs_t;

    typedef struct packed {
        logic [7:0] brg_cnt;
        logic       sg_act;
        logic [2:0] sg_cnt;
        logic [3:0] sg_edge;
        logic       sck_int;
        scu_tx_st_t tx_st;
        logic [9:0] tx_shift_reg;
        logic [3:0] tx_cnt;
        logic [3:0] tx_sub;
        logic       txd;
        logic       rx_act;
        logic [8:0] rx_shift_reg;
        logic [3:0] rx_cnt;
        logic [3:0] rx_sub;
    } scu_eng_t;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] SCU_CTRL_RST = 16'h0000;
    localparam logic [15:0] SCU_STAT_RST = 16'h0021; // empty and end set
    localparam logic [7:0]  SCU_BAUD_RST = 8'h0F;
    localparam scu_regs_t SCU_REGS_RST = '{ctrl: SCU_CTRL_RST, stat: SCU_STAT_RST,
                                           baud: SCU_BAUD_RST, default: '0};
    localparam scu_eng_t SCU_ENG_RST = '{sck_int: 1'b1, txd: 1'b1,
                                         tx_st: SCU_TX_IDLE, default: '0};

endpackage

// file: rtl/scu_serial.sv
/*
 * serial_comm_unit: asynchronous (with multiprocessor format) and clock
 * synchronous 8-bit serial transfer, registers on a plain port.
 * assumes rxd_in and sck_in are asynchronous pins and that software
 * disables both directions before changing mode or format.
 */
// Function
// - extra frame bit: 1 is ID, 0 data
// - filter on: drop frames until ID frame
// - ID frame: set flag, clear filter, store
// - multiprocessor format ignores parity setting
// - sent flag bit comes from software control
// - synchronous character is exactly 8 data bits
// - drive on falling, sample on rising edge
// - LSB first, line holds MSB afterwards
// - double-buffered transmitter and receiver, independent in async mode only
// - internal clock: 8 pulses, idle high
// - transmit disable sets empty; receive disable keeps
// - empty clear: load shifter, set empty
// - last bit: chain or set end, hold
// - synchronous transmit blocked by error flags
// - full on completion: overrun, discard data
// - good character: store, set full
// - no reception while error flags set
// - controller read clears full automatically
// - async order: start, data, extra, stop
module scu_serial (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [2:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // transfer_controller port
    input  wire logic        xfer_tx_wr,
    input  wire logic [7:0]  xfer_tx_data,
    input  wire logic        xfer_rx_rd,
    output logic      [7:0]  rx_data,
    // serial pins
    input  wire logic        rxd_in,
    output logic             txd_out,
    output logic             txd_oe,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    // interrupt requests
    output logic             rx_full_irq,
    output logic             rx_error_irq,
    output logic             tx_empty_irq,
    output logic             tx_end_irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    scu_pkg::scu_regs_t r, next_r;        // software visible state
    scu_pkg::scu_eng_t  e, next_e;        // shifters and counters
    logic [15:0]        next_rdata;       // read answer
    scu_pkg::scu_stat_t ws;               // write data as status
    logic rxd_s1, rxd_s;                  // receive pin synchroniser
    logic sck_s1, sck_s2, sck_s3;         // clock pin synchroniser
    logic brg_tick, t16, tog, frame_end;  // timing events
    logic s_fall, s_rise;                 // shift clock edges
    logic sync_m, int_sync, err, has_ext; // mode terms
    logic tx_load, sg_want, sg_start;     // engine controls
    logic c_done, c_ext, c_stop, c_per;   // character completion
    logic [7:0] c_data;                   // completed character
    logic [3:0] tx_last, rx_last;         // frame length by format

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // two flops on each pin; third clock flop only for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_s1 <= 1'b1;
            rxd_s  <= 1'b1;
            sck_s1 <= 1'b1;
            sck_s2 <= 1'b1;
            sck_s3 <= 1'b1;
        end else begin
            rxd_s1 <= rxd_in;
            rxd_s  <= rxd_s1;
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
        end
    end

    // ------------------------------------------------------------------
    // mode and timing terms
    // ------------------------------------------------------------------
    assign ws        = wdata;
    assign sync_m    = r.ctrl.sync_mode;
    assign int_sync  = sync_m & ~r.ctrl.clk_sel_hi;
    assign err       = r.stat.overrun_err_flag | r.stat.framing_err_flag
                     | r.stat.parity_err_flag;
    assign has_ext   = r.ctrl.mp_fmt | r.ctrl.par_en;
    assign tx_last   = has_ext ? scu_pkg::SCU_LAST_EXT : scu_pkg::SCU_LAST_PLN;
    assign rx_last   = tx_last;
    assign brg_tick  = (e.brg_cnt == 8'h00);
    // external clock is 16x bit rate in async mode
    assign t16       = r.ctrl.clk_sel_hi ? (sck_s2 & ~sck_s3) : brg_tick;
    assign tog       = e.sg_act & brg_tick & (e.sg_cnt == scu_pkg::SCU_HALF_LAST);
    assign frame_end = tog & (e.sg_edge == scu_pkg::SCU_EDGE_LAST);
    // shift clock edges, internal or synchronised pin
    assign s_fall    = r.ctrl.clk_sel_hi ? (~sck_s2 & sck_s3) : (tog & e.sck_int);
    assign s_rise    = r.ctrl.clk_sel_hi ? (sck_s2 & ~sck_s3) : (tog & ~e.sck_int);
    // with the internal shift clock, start the transmitter only at a frame boundary of that clock
    assign tx_load   = r.ctrl.tx_enable_bit & (e.tx_st == scu_pkg::SCU_TX_IDLE)
                     & ~r.stat.tx_empty_flag
                     & (~sync_m | (~err & (r.ctrl.clk_sel_hi | ~e.sg_act
                     | frame_end)));
    assign sg_want   = int_sync & (tx_load | (e.tx_st == scu_pkg::SCU_TX_RUN)
                     | (r.ctrl.rx_enable_bit & ~err));
    assign sg_start  = ~e.sg_act & sg_want;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r     = r;
        next_e     = e;
        next_rdata = 16'h0000;
        c_done     = 1'b0;
        c_data     = 8'h00;
        c_ext      = 1'b0;
        c_stop     = 1'b1;
        // register reads, unmapped answer zero
        if (rd) begin
            case (addr)
                scu_pkg::SCU_A_CTRL: next_rdata = r.ctrl;
                scu_pkg::SCU_A_STAT: next_rdata = r.stat;
                scu_pkg::SCU_A_TXB:  next_rdata = {8'h00, r.txbuf};
                scu_pkg::SCU_A_RXB:  next_rdata = {8'h00, r.rxbuf};
                scu_pkg::SCU_A_BAUD: next_rdata = {8'h00, r.baud};
                default:             next_rdata = 16'h0000;
            endcase
        end
        // register writes; empty, full and error flags clear where a 0 is written
        if (wr) begin
            case (addr)
                scu_pkg::SCU_A_CTRL: begin
                    next_r.ctrl     = wdata;
                    next_r.ctrl.rsv = 4'h0;
                end
                scu_pkg::SCU_A_STAT: begin
                    next_r.stat.tx_empty_flag    = r.stat.tx_empty_flag & ws.tx_empty_flag;
                    next_r.stat.rx_full_flag     = r.stat.rx_full_flag & ws.rx_full_flag;
                    next_r.stat.overrun_err_flag = r.stat.overrun_err_flag & ws.overrun_err_flag;
                    next_r.stat.framing_err_flag = r.stat.framing_err_flag & ws.framing_err_flag;
                    next_r.stat.parity_err_flag  = r.stat.parity_err_flag & ws.parity_err_flag;
                    next_r.stat.tx_multiproc_flag_bit = ws.tx_multiproc_flag_bit;
                end
                scu_pkg::SCU_A_TXB:  next_r.txbuf = wdata[7:0];
                scu_pkg::SCU_A_BAUD: next_r.baud  = wdata[7:0];
                default: begin
                end
            endcase
        end
        // controller writes data and clears empty in one step
        if (xfer_tx_wr) begin
            next_r.txbuf               = xfer_tx_data;
            next_r.stat.tx_empty_flag  = 1'b0;
        end
        // controller read of the buffer clears full
        if (xfer_rx_rd) begin
            next_r.stat.rx_full_flag = 1'b0;
        end
        // baud divider
        next_e.brg_cnt = brg_tick ? r.baud : e.brg_cnt - 8'h01;
        // internal shift clock: 16 edges per character, idle high
        if (sg_start) begin
            next_e.sg_act  = 1'b1;
            next_e.sg_cnt  = 3'h0;
            next_e.sg_edge = 4'h0;
        end else if (e.sg_act && brg_tick) begin
            next_e.sg_cnt = e.sg_cnt + 3'h1;
            if (tog) begin
                next_e.sck_int = ~e.sck_int;
                next_e.sg_edge = e.sg_edge + 4'h1;
                if (frame_end) begin
                    next_e.sg_act = sg_want;
                end
            end
        end
        // transmitter
        if (!r.ctrl.tx_enable_bit) begin
            next_e.tx_st = scu_pkg::SCU_TX_IDLE;
            next_e.txd   = 1'b1;
        end else if (tx_load) begin
            // frame after the start bit: data, extra, stop
            if (sync_m) begin
                next_e.tx_shift_reg = {2'b11, r.txbuf};
            end else if (r.ctrl.mp_fmt) begin
                next_e.tx_shift_reg = {1'b1, r.stat.tx_multiproc_flag_bit, r.txbuf};
            end else begin
                next_e.tx_shift_reg = {1'b1, r.ctrl.par_en ? (^r.txbuf ^ r.ctrl.par_odd)
                                                  : 1'b1, r.txbuf};
            end
            next_r.stat.tx_empty_flag = 1'b1;
            next_r.stat.tx_end_flag   = 1'b0;
            next_e.tx_st  = scu_pkg::SCU_TX_RUN;
            next_e.tx_cnt = 4'h0;
            next_e.tx_sub = 4'h0;
            if (!sync_m) begin
                next_e.txd = 1'b0;
            end
        end else if (e.tx_st == scu_pkg::SCU_TX_RUN) begin
            if (sync_m) begin
                // one bit per falling edge, LSB first
                if (s_fall) begin
                    next_e.txd    = e.tx_shift_reg[0];
                    next_e.tx_shift_reg    = {1'b1, e.tx_shift_reg[9:1]};
                    next_e.tx_cnt = e.tx_cnt + 4'h1;
                    if (e.tx_cnt == scu_pkg::SCU_SYNC_LAST) begin
                        // last bit: reload follows, else hold MSB
                        next_e.tx_st = scu_pkg::SCU_TX_IDLE;
                        if (r.stat.tx_empty_flag) begin
                            next_r.stat.tx_end_flag = 1'b1;
                        end
                    end
                end
            end else if (t16) begin
                next_e.tx_sub = e.tx_sub + 4'h1;
                if (e.tx_sub == scu_pkg::SCU_OVS_LAST) begin
                    if (e.tx_cnt == tx_last) begin
                        next_e.tx_st = scu_pkg::SCU_TX_IDLE;
                    end else begin
                        next_e.txd    = e.tx_shift_reg[0];
                        next_e.tx_shift_reg    = {1'b1, e.tx_shift_reg[9:1]};
                        next_e.tx_cnt = e.tx_cnt + 4'h1;
                        // check the empty flag as the stop bit starts
                        if ((e.tx_cnt + 4'h1 == tx_last) && r.stat.tx_empty_flag) begin
                            next_r.stat.tx_end_flag = 1'b1;
                        end
                    end
                end
            end
        end
        // receiver, held while disabled or an error flag stands
        if (!r.ctrl.rx_enable_bit || err) begin
            next_e.rx_act = 1'b0;
            next_e.rx_cnt = 4'h0;
            next_e.rx_sub = 4'h0;
        end else if (sync_m) begin
            if (sg_start) begin
                next_e.rx_cnt = 4'h0;
            end else if (s_rise) begin
                next_e.rx_shift_reg    = {rxd_s, e.rx_shift_reg[8:1]};
                next_e.rx_cnt = e.rx_cnt + 4'h1;
                if (e.rx_cnt == scu_pkg::SCU_SYNC_LAST) begin
                    next_e.rx_cnt = 4'h0;
                    c_done        = 1'b1;
                    c_data        = {rxd_s, e.rx_shift_reg[8:2]};
                end
            end
        end else if (!e.rx_act) begin
            // start bit seen as a low line
            if (!rxd_s) begin
                next_e.rx_act = 1'b1;
                next_e.rx_cnt = 4'h0;
                next_e.rx_sub = 4'h0;
            end
        end else if (t16) begin
            next_e.rx_sub = e.rx_sub + 4'h1;
            if (e.rx_sub == scu_pkg::SCU_MID) begin
                next_e.rx_cnt = e.rx_cnt + 4'h1;
                if (e.rx_cnt == 4'h0 && rxd_s) begin
                    next_e.rx_act = 1'b0;                        // false start
                end else if (e.rx_cnt == rx_last) begin
                    next_e.rx_act = 1'b0;
                    c_done        = 1'b1;
                    c_stop        = rxd_s;
                    c_data        = has_ext ? e.rx_shift_reg[7:0] : e.rx_shift_reg[8:1];
                    c_ext         = has_ext & e.rx_shift_reg[8];
                end else if (e.rx_cnt != 4'h0) begin
                    next_e.rx_shift_reg = {rxd_s, e.rx_shift_reg[8:1]};
                end
            end
        end
        // parity check only in plain async format
        c_per = r.ctrl.par_en & ~r.ctrl.mp_fmt & ~sync_m
              & ((^{c_data, c_ext}) != r.ctrl.par_odd);
        // character completion
        if (c_done && !(r.ctrl.multiproc_rx_filter_en && r.ctrl.mp_fmt && !c_ext)) begin
            if (r.ctrl.mp_fmt) begin
                next_r.stat.rx_multiproc_flag_bit = c_ext;
                if (c_ext) begin
                    next_r.ctrl.multiproc_rx_filter_en = 1'b0;
                end
            end
            if (!c_stop) begin
                next_r.stat.framing_err_flag = 1'b1;
            end
            if (c_per) begin
                next_r.stat.parity_err_flag = 1'b1;
            end
            if (r.stat.rx_full_flag) begin
                next_r.stat.overrun_err_flag = 1'b1;
                next_r.stat.rx_full_flag     = 1'b1;
            end else begin
                next_r.rxbuf = c_data;
                if (c_stop && !c_per) begin
                    next_r.stat.rx_full_flag = 1'b1;
                end
            end
        end
        // transmit disable forces empty
        if (!r.ctrl.tx_enable_bit) begin
            next_r.stat.tx_empty_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r     <= scu_pkg::SCU_REGS_RST;
            e     <= scu_pkg::SCU_ENG_RST;
            rdata <= 16'h0000;
        end else begin
            r     <= next_r;
            e     <= next_e;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rx_data      = r.rxbuf;
    assign txd_out      = e.txd;
    assign txd_oe       = r.ctrl.tx_enable_bit;
    assign sck_out      = e.sck_int;
    assign sck_oe       = int_sync;
    assign rx_full_irq  = r.stat.rx_full_flag & r.ctrl.rx_irq_en;
    assign rx_error_irq = err & r.ctrl.rx_irq_en;
    assign tx_empty_irq = r.stat.tx_empty_flag & r.ctrl.tx_irq_en;
    assign tx_end_irq   = r.stat.tx_end_flag & r.ctrl.tx_end_irq_en;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_sync_last;
        sync_m && e.tx_st == scu_pkg::SCU_TX_RUN && s_fall
            && e.tx_cnt == scu_pkg::SCU_SYNC_LAST && r.ctrl.tx_enable_bit;
    endsequence

    AST_MP_SKIP: assert property (c_done && r.ctrl.multiproc_rx_filter_en
        && r.ctrl.mp_fmt && !c_ext |=> $stable(r.rxbuf) && !$rose(r.stat.overrun_err_flag))
        else $error("filtered frame changed receive state");
    AST_MP_ID: assert property (c_done && r.ctrl.multiproc_rx_filter_en
        && r.ctrl.mp_fmt && c_ext && !wr |=> r.stat.rx_multiproc_flag_bit
        && !r.ctrl.multiproc_rx_filter_en)
        else $error("ID frame did not end filtering");
    AST_TE_OFF: assert property (!r.ctrl.tx_enable_bit |=> r.stat.tx_empty_flag)
        else $error("empty flag low while transmit disabled");
    AST_LOAD: assert property (tx_load |=> e.tx_st == scu_pkg::SCU_TX_RUN
        && r.stat.tx_empty_flag && !r.stat.tx_end_flag)
        else $error("load did not start transmitter");
    AST_LAST_BIT: assert property (s_sync_last ##0 r.stat.tx_empty_flag
        |=> r.stat.tx_end_flag && txd_out == $past(e.tx_shift_reg[0]) ##1 $stable(txd_out))
        else $error("end of transmission not flagged");
    AST_ERR_HOLD: assert property (sync_m && err && e.tx_st == scu_pkg::SCU_TX_IDLE
        |=> e.tx_st == scu_pkg::SCU_TX_IDLE)
        else $error("synchronous transmit started over error");
    AST_OVERRUN: assert property (c_done && !r.ctrl.multiproc_rx_filter_en
        && r.stat.rx_full_flag && !wr && !xfer_rx_rd |=> r.stat.overrun_err_flag
        && r.stat.rx_full_flag && $stable(r.rxbuf))
        else $error("overrun not handled");
    AST_RX_OK: assert property (c_done && !r.ctrl.multiproc_rx_filter_en
        && !r.stat.rx_full_flag && c_stop && !c_per |=> r.stat.rx_full_flag
        && r.rxbuf == $past(c_data))
        else $error("good character not stored");
    AST_SCK_IDLE: assert property (int_sync && !e.sg_act |-> sck_out && sck_oe)
        else $error("internal clock not high when idle");

endmodule

// file: verification/scu_peer.sv
/* far-side peer: an async station and a clocked source (64 ns shift clock).
   assumes 256 system clocks per async bit, the unit's reset divisor. */
module scu_peer (
    // system clock for async bit timing
    input  wire logic clk,
    // serial lines toward the unit
    output logic      rxd,
    output logic      sck
);
    timeunit 1ns;
    timeprecision 1ps;
    // line pulled high, shift clock rests high
    initial begin
        rxd = 1'b1;
        sck = 1'b1;
    end
    // async frame: start, data lsb first, flag bit, stop
    task automatic send(input logic [7:0] d, input logic mp);
        logic [10:0] f;
        f = {1'b1, mp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (256) @(posedge clk);
        end
    endtask
    // clocked byte: data changes on falls, stable over rises, then the inverse of the last bit left on the line
    task automatic sync_send(input logic [7:0] d);
        #3;
        for (int i = 0; i < 8; i++) begin
            sck = 1'b0;
            rxd = d[i];
            #32;
            sck = 1'b1;
            #32;
        end
        rxd = ~d[7];
        // hand back on a clock edge so the bench drives right after it
        @(posedge clk);
    endtask
endmodule

// file: verification/tb_scu_serial.sv
/* bench for the serial unit: registers, async multiprocessor and sync links.
   assumes the peer model on the receive and external clock pins. */
module tb_scu_serial;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, xrd = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [7:0]  rx_data, b;
    logic        rxd, sck, txd_out, sck_out, rx_full_irq;
    logic        txd_oe, sck_oe, rx_error_irq, tx_empty_irq, tx_end_irq;
    int          n_errors = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    scu_serial dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .xfer_tx_wr(1'b0), .xfer_tx_data(8'h00), .xfer_rx_rd(xrd),
        .rx_data(rx_data), .rxd_in(rxd), .txd_out(txd_out), .txd_oe(txd_oe), .sck_in(sck),
        .sck_out(sck_out), .sck_oe(sck_oe), .rx_full_irq(rx_full_irq),
        .rx_error_irq(rx_error_irq), .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq));
    scu_peer peer_u (.clk(clk), .rxd(rxd), .sck(sck));
    task automatic results();
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // one register cycle; a read compares the data of the following cycle
    task automatic bus(input bit w, input logic [2:0] a, input logic [15:0] d, input string n);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge clk);
        if (!w) check(n, rdata, d);
        @(posedge clk);
    endtask
    // bounded wait for the shift clock or the transmit line
    task automatic wait_on(input bit s, input logic v);
        for (int n = 0; (s ? sck_out : txd_out) !== v; n++) begin
            if (n == 9000) begin
                n_errors++;
                results();
            end
            @(posedge clk);
        end
    endtask
    task automatic t_mp_tx();
        logic [10:0] f;
        bus(0, 3'h1, 16'h0021, "stat");
        bus(0, 3'h7, 16'h0000, "hole");
        bus(1, 3'h0, 16'h0019, "");
        bus(1, 3'h2, 16'h00A5, "");
        bus(1, 3'h1, 16'h0080, "");
        wait_on(0, 1'b0);
        repeat (128) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd_out;
            repeat (256) @(posedge clk);
        end
        check("frame", 16'(f), {5'h00, 2'b11, 8'hA5, 1'b0});
        bus(0, 3'h1, 16'h00A1, "stat");
    endtask
    task automatic t_mp_rx();
        bus(1, 3'h0, 16'h0000, "");
        bus(1, 3'h0, 16'h030A, "");
        peer_u.send(8'h11, 1'b0);
        bus(0, 3'h1, 16'h00A1, "stat");
        peer_u.send(8'h5C, 1'b1);
        bus(0, 3'h1, 16'h00E3, "stat");
        bus(0, 3'h0, 16'h020A, "ctrl");
        check("rxbuf", {8'h00, rx_data}, 16'h005C);
        check("irq", {15'h0, rx_full_irq}, 16'h0001);
        xrd <= 1'b1;
        @(posedge clk);
        xrd <= 1'b0;
        @(posedge clk);
        check("irq", {15'h0, rx_full_irq}, 16'h0000);
    endtask
    task automatic t_sync_tx();
        bus(1, 3'h0, 16'h0000, "");
        bus(1, 3'h0, 16'h0C05, "");
        bus(1, 3'h2, 16'h004B, "");
        bus(1, 3'h1, 16'h0000, "");
        for (int i = 0; i < 8; i++) begin
            wait_on(1, 1'b0);
            wait_on(1, 1'b1);
            b[i] = txd_out;
            if (i == 0) check("tirq", {14'h0, tx_end_irq, tx_empty_irq}, 16'h0001);
        end
        repeat (300) @(posedge clk);
        check("byte", {8'h00, b}, 16'h004B);
        check("line", {14'h0, sck_out, txd_out}, 16'h0002);
        check("tirq", {14'h0, tx_end_irq, tx_empty_irq}, 16'h0003);
        check("oe", {14'h0, sck_oe, txd_oe}, 16'h0003);
        bus(0, 3'h1, 16'h0061, "stat");
    endtask
    task automatic t_ext_rx();
        bus(1, 3'h0, 16'h0000, "");
        bus(1, 3'h0, 16'h0286, "");
        peer_u.sync_send(8'h96);
        bus(0, 3'h1, 16'h0063, "stat");
        check("rxbuf", {8'h00, rx_data}, 16'h0096);
        check("oe", {14'h0, sck_oe, txd_oe}, 16'h0000);
        peer_u.sync_send(8'h3A);
        bus(0, 3'h1, 16'h0067, "stat");
        check("eirq", {15'h0, rx_error_irq}, 16'h0001);
        bus(1, 3'h0, 16'h0000, "");
        bus(0, 3'h1, 16'h0067, "stat");
        check("rxbuf", {8'h00, rx_data}, 16'h0096);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_mp_tx();
        t_mp_rx();
        t_sync_tx();
        t_ext_rx();
        results();
    end
endmodule
